// >>> rtl/dcr_capability_regs.sv
// device capability registers and the masked clock gating registers
`timescale 1ns/1ps

// Operation
// - sram size field, bits 31:16 of memory capability, reads 0x07 (2 KB)
// - flash size field, bits 15:0 of memory capability, reads 0x03 (8 KB)
// - minimum system divider, bits 15:12 of core capability, reads 0x09
// - memory protection bit 7 of core capability reads 0
// - pll, watchdog, trace, serial debug and jtag bits 4:0 read 1
// - watchdog, trace, debug, jtag bits mask writes to group 0 gating
// - group 0 gating bits without a mask bit are stored as 0
// - written converter sample rate is clipped to the allowed maximum
// - peripheral capability masks writes to group 1 gating registers
// - comparator one and zero bits 25 and 24 read 1
// - timer one and zero bits 17 and 16 read 1
// - sync serial bit 4 and first uart bit 0 read 1
// - reserved bits may read anything; software never changes them
module dcr_capability_regs (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire dcr_pkg::dcr_bus_s     busIn,
	input  wire dcr_pkg::dcr_mode_e    powerMode,
	output logic [31:0]                rdData_r,
	output logic [31:0]                gateRun0_r,
	output logic [31:0]                gateRun1_r,
	output logic [31:0]                gateSleep0_r,
	output logic [31:0]                gateSleep1_r,
	output logic [31:0]                gateDeep0_r,
	output logic [31:0]                gateDeep1_r,
	output logic [31:0]                activeGate0_r,
	output logic [31:0]                activeGate1_r
);

	//----------------------------------------------------------------
	// address decode
	//----------------------------------------------------------------
	function automatic logic [dcr_pkg::GATE_N-1:0] gateSel(
		input logic [dcr_pkg::ADDR_W-1:0] addr
	);
		logic [dcr_pkg::GATE_N-1:0] sel;
		sel = '0;
		for (int i = 0; i < dcr_pkg::GATE_N; i++) begin
			sel[i] = (addr == dcr_pkg::GATE_OFS[i]);
		end
		return sel;
	endfunction

	function automatic logic isGroup0(input int idx);
		return (idx % 2) == 0;
	endfunction

	//----------------------------------------------------------------
	// gating registers
	//----------------------------------------------------------------
	logic [dcr_pkg::GATE_N-1:0] wrSel;
	logic [dcr_pkg::GATE_N-1:0] rdSel;
	logic [31:0]                gateVal [dcr_pkg::GATE_N];

	// capability offsets are absent here, so their writes are dropped
	assign wrSel = busIn.wrStb ? gateSel(busIn.addr) : '0;

	generate
		for (genvar g = 0; g < dcr_pkg::GATE_N; g++) begin : gen_gate
			dcr_gate_reg #(
				.WR_MASK  (isGroup0(g) ? dcr_pkg::GROUP0_MASK
				                       : dcr_pkg::GROUP1_MASK),
				.RST_VAL  (dcr_pkg::GATE_RST),
				.CLIP_EN  (isGroup0(g)),
				.RATE_MAX (dcr_pkg::CONV_RATE_MAX)
			) u_gate (
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.wrEn    (wrSel[g]),
				.wrData  (busIn.wrData),
				.gateVal (gateVal[g])
			);
		end
	endgenerate

	//----------------------------------------------------------------
	// read path
	//----------------------------------------------------------------
	logic [31:0] rdData_nxt;
	logic [31:0] gateRead;

	assign rdSel = gateSel(busIn.addr);

	always_comb begin
		gateRead = '0;
		for (int i = 0; i < dcr_pkg::GATE_N; i++) begin
			gateRead = gateRead | (rdSel[i] ? gateVal[i] : '0);
		end
		rdData_nxt = '0;
		if (busIn.rdStb) begin
			case (busIn.addr)
				dcr_pkg::OFS_MEMORY_SIZE_CAPABILITY: begin
					rdData_nxt = dcr_pkg::MEMORY_SIZE_CAPABILITY;
				end
				dcr_pkg::OFS_CORE_DEBUG_CAPABILITY: begin
					rdData_nxt = dcr_pkg::CORE_DEBUG_CAPABILITY;
				end
				dcr_pkg::OFS_PERIPHERAL_CAPABILITY: begin
					rdData_nxt = dcr_pkg::PERIPHERAL_CAPABILITY;
				end
				default: begin
					rdData_nxt = gateRead;
				end
			endcase
		end
	end

	//----------------------------------------------------------------
	// gating that applies in the present power mode
	//----------------------------------------------------------------
	logic [31:0] activeGate0_nxt;
	logic [31:0] activeGate1_nxt;

	always_comb begin
		case (powerMode)
			dcr_pkg::MODE_RUN: begin
				activeGate0_nxt = gateVal[dcr_pkg::G_RUN0];
				activeGate1_nxt = gateVal[dcr_pkg::G_RUN1];
			end
			dcr_pkg::MODE_SLEEP: begin
				activeGate0_nxt = gateVal[dcr_pkg::G_SLEEP0];
				activeGate1_nxt = gateVal[dcr_pkg::G_SLEEP1];
			end
			dcr_pkg::MODE_DEEP: begin
				activeGate0_nxt = gateVal[dcr_pkg::G_DEEP0];
				activeGate1_nxt = gateVal[dcr_pkg::G_DEEP1];
			end
			default: begin
				activeGate0_nxt = gateVal[dcr_pkg::G_RUN0];
				activeGate1_nxt = gateVal[dcr_pkg::G_RUN1];
			end
		endcase
	end

	//----------------------------------------------------------------
	// output registers
	//----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdData_r      <= '0;
			gateRun0_r    <= dcr_pkg::GATE_RST;
			gateRun1_r    <= dcr_pkg::GATE_RST;
			gateSleep0_r  <= dcr_pkg::GATE_RST;
			gateSleep1_r  <= dcr_pkg::GATE_RST;
			gateDeep0_r   <= dcr_pkg::GATE_RST;
			gateDeep1_r   <= dcr_pkg::GATE_RST;
			activeGate0_r <= dcr_pkg::GATE_RST;
			activeGate1_r <= dcr_pkg::GATE_RST;
		end else begin
			rdData_r      <= rdData_nxt;
			gateRun0_r    <= gateVal[dcr_pkg::G_RUN0];
			gateRun1_r    <= gateVal[dcr_pkg::G_RUN1];
			gateSleep0_r  <= gateVal[dcr_pkg::G_SLEEP0];
			gateSleep1_r  <= gateVal[dcr_pkg::G_SLEEP1];
			gateDeep0_r   <= gateVal[dcr_pkg::G_DEEP0];
			gateDeep1_r   <= gateVal[dcr_pkg::G_DEEP1];
			activeGate0_r <= activeGate0_nxt;
			activeGate1_r <= activeGate1_nxt;
		end
	end

	//----------------------------------------------------------------
	// checks
	//----------------------------------------------------------------
	default clocking cbMain @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence seqRead(logic [dcr_pkg::ADDR_W-1:0] ofs);
		busIn.rdStb && (busIn.addr == ofs);
	endsequence

	sequence seqWrite(logic [dcr_pkg::ADDR_W-1:0] ofs);
		busIn.wrStb && (busIn.addr == ofs);
	endsequence

	// port image of a gating write settles two edges after the strobe
	sequence seqGateLag(logic [dcr_pkg::ADDR_W-1:0] ofs);
		seqWrite(ofs) ##2 1'b1;
	endsequence

	chk_sram_size: assert property (
		seqRead(dcr_pkg::OFS_MEMORY_SIZE_CAPABILITY)
		|=> rdData_r[31:16] == 16'h0007
	) else $error("sram size field wrong");

	chk_flash_size: assert property (
		seqRead(dcr_pkg::OFS_MEMORY_SIZE_CAPABILITY)
		|=> rdData_r[15:0] == 16'h0003
	) else $error("flash size field wrong");

	chk_sys_divider: assert property (
		seqRead(dcr_pkg::OFS_CORE_DEBUG_CAPABILITY)
		|=> rdData_r[15:12] == 4'h9
	) else $error("minimum divider field wrong");

	chk_mem_prot: assert property (
		seqRead(dcr_pkg::OFS_CORE_DEBUG_CAPABILITY)
		|=> !rdData_r[7]
	) else $error("memory protection bit set");

	chk_core_bits: assert property (
		seqRead(dcr_pkg::OFS_CORE_DEBUG_CAPABILITY)
		|=> rdData_r[4:0] == 5'h1F
	) else $error("core capability bits wrong");

	chk_group0_mask: assert property (
		seqWrite(dcr_pkg::GATE_OFS[dcr_pkg::G_RUN0])
		|=> ##1 (gateRun0_r & ~dcr_pkg::CONV_RATE_FIELD)
		        == ($past(busIn.wrData, 2) & dcr_pkg::GROUP0_MASK)
	) else $error("group 0 mask not applied");

	chk_group0_zero: assert property (
		seqWrite(dcr_pkg::GATE_OFS[dcr_pkg::G_DEEP0])
		|=> ##1 (gateDeep0_r & ~dcr_pkg::GROUP0_MASK
		         & ~dcr_pkg::CONV_RATE_FIELD) == 32'h0000_0000
		     && (gateDeep0_r & dcr_pkg::GROUP0_MASK)
		        == ($past(busIn.wrData, 2) & dcr_pkg::GROUP0_MASK)
	) else $error("group 0 unmasked bit stored");

	chk_rate_clip: assert property (
		gateVal[dcr_pkg::G_RUN0][9:8] <= dcr_pkg::CONV_RATE_MAX
		&& gateVal[dcr_pkg::G_SLEEP0][9:8] <= dcr_pkg::CONV_RATE_MAX
		&& gateVal[dcr_pkg::G_DEEP0][9:8] <= dcr_pkg::CONV_RATE_MAX
	) else $error("sample rate above maximum");

	chk_group1_mask: assert property (
		seqWrite(dcr_pkg::GATE_OFS[dcr_pkg::G_RUN1])
		|=> ##1 gateRun1_r == ($past(busIn.wrData, 2) & dcr_pkg::GROUP1_MASK)
	) else $error("group 1 mask not applied");

	chk_comparators: assert property (
		seqRead(dcr_pkg::OFS_PERIPHERAL_CAPABILITY)
		|=> rdData_r[25:24] == 2'h3
	) else $error("comparator bits wrong");

	chk_timers: assert property (
		seqRead(dcr_pkg::OFS_PERIPHERAL_CAPABILITY)
		|=> rdData_r[17:16] == 2'h3
	) else $error("timer bits wrong");

	chk_serial_uart: assert property (
		seqRead(dcr_pkg::OFS_PERIPHERAL_CAPABILITY)
		|=> rdData_r[4] && rdData_r[0]
	) else $error("serial or uart bit wrong");

	chk_cap_write: assert property (
		seqWrite(dcr_pkg::OFS_CORE_DEBUG_CAPABILITY)
		##1 seqRead(dcr_pkg::OFS_CORE_DEBUG_CAPABILITY)
		|=> rdData_r == dcr_pkg::CORE_DEBUG_CAPABILITY
		    && $stable(gateRun0_r)
	) else $error("capability write took effect");

	chk_idle_read: assert property (
		!busIn.rdStb |=> rdData_r == 32'h0000_0000
	) else $error("read data outside answer cycle");

	chk_reserved_core: assert property (
		seqRead(dcr_pkg::OFS_CORE_DEBUG_CAPABILITY)
		|=> (rdData_r & dcr_pkg::RESERVED_CORE_MASK) == 32'h0000_0000
	) else $error("core reserved bits not zero");

	chk_peri_word: assert property (
		seqRead(dcr_pkg::OFS_PERIPHERAL_CAPABILITY)
		|=> rdData_r == 32'h0303_0011
	) else $error("peripheral capability word wrong");

	chk_mem_write: assert property (
		seqWrite(dcr_pkg::OFS_MEMORY_SIZE_CAPABILITY)
		##1 seqRead(dcr_pkg::OFS_MEMORY_SIZE_CAPABILITY)
		|=> rdData_r == 32'h0007_0003
	) else $error("memory capability write took effect");

	chk_peri_write: assert property (
		seqWrite(dcr_pkg::OFS_PERIPHERAL_CAPABILITY)
		##1 seqRead(dcr_pkg::OFS_PERIPHERAL_CAPABILITY)
		|=> rdData_r == 32'h0303_0011
	) else $error("peripheral capability write took effect");

	chk_unmapped_read: assert property (
		seqRead(12'h00C) |=> rdData_r == 32'h0000_0000
	) else $error("unmapped read not zero");

	chk_run1_read: assert property (
		seqRead(dcr_pkg::GATE_OFS[dcr_pkg::G_RUN1]) |=> rdData_r == gateRun1_r
	) else $error("group 1 run read back wrong");

	//----------------------------------------------------------------
	// gating checks
	//----------------------------------------------------------------
	chk_sleep0_mask: assert property (
		seqGateLag(dcr_pkg::GATE_OFS[dcr_pkg::G_SLEEP0])
		|-> (gateSleep0_r & ~dcr_pkg::CONV_RATE_FIELD)
		    == ($past(busIn.wrData, 2) & dcr_pkg::GROUP0_MASK)
	) else $error("sleep group 0 mask not applied");

	chk_sleep1_mask: assert property (
		seqGateLag(dcr_pkg::GATE_OFS[dcr_pkg::G_SLEEP1])
		|-> gateSleep1_r == ($past(busIn.wrData, 2) & dcr_pkg::GROUP1_MASK)
	) else $error("sleep group 1 mask not applied");

	chk_deep1_mask: assert property (
		seqGateLag(dcr_pkg::GATE_OFS[dcr_pkg::G_DEEP1])
		|-> gateDeep1_r == ($past(busIn.wrData, 2) & dcr_pkg::GROUP1_MASK)
	) else $error("deep group 1 mask not applied");

	chk_rate_write: assert property (
		seqGateLag(dcr_pkg::GATE_OFS[dcr_pkg::G_RUN0])
		|-> gateRun0_r[9:8] == (($past(busIn.wrData[9:8], 2) > dcr_pkg::CONV_RATE_MAX)
		    ? dcr_pkg::CONV_RATE_MAX : $past(busIn.wrData[9:8], 2))
	) else $error("run sample rate not clipped");

	chk_deep_rate: assert property (
		seqGateLag(dcr_pkg::GATE_OFS[dcr_pkg::G_DEEP0])
		|-> gateDeep0_r[9:8] == (($past(busIn.wrData[9:8], 2) > dcr_pkg::CONV_RATE_MAX)
		    ? dcr_pkg::CONV_RATE_MAX : $past(busIn.wrData[9:8], 2))
	) else $error("deep sample rate not clipped");

	chk_active_run: assert property (
		powerMode != dcr_pkg::MODE_SLEEP && powerMode != dcr_pkg::MODE_DEEP
		|=> activeGate0_r == $past(gateVal[dcr_pkg::G_RUN0])
		    && activeGate1_r == $past(gateVal[dcr_pkg::G_RUN1])
	) else $error("run mode gating not selected");

	chk_active_sleep: assert property (
		powerMode == dcr_pkg::MODE_SLEEP
		|=> activeGate0_r == $past(gateVal[dcr_pkg::G_SLEEP0])
		    && activeGate1_r == $past(gateVal[dcr_pkg::G_SLEEP1])
	) else $error("sleep mode gating not selected");

	chk_active_deep: assert property (
		powerMode == dcr_pkg::MODE_DEEP
		|=> activeGate0_r == $past(gateVal[dcr_pkg::G_DEEP0])
		    && activeGate1_r == $past(gateVal[dcr_pkg::G_DEEP1])
	) else $error("deep mode gating not selected");

endmodule

// >>> rtl/dcr_gate_reg.sv
// one clock gating register with capability write mask and rate clipping
`timescale 1ns/1ps
module dcr_gate_reg #(
	parameter logic [31:0] WR_MASK  = 32'h0000_0000,
	parameter logic [31:0] RST_VAL  = 32'h0000_0000,
	parameter bit          CLIP_EN  = 1'b0,
	parameter logic [1:0]  RATE_MAX = 2'h0
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        wrEn,
	input  wire logic [31:0] wrData,
	output logic      [31:0] gateVal
);

	logic [31:0] gateVal_r;
	logic [31:0] gateVal_nxt;
	logic [1:0]  rateReq;

	always_comb begin
		rateReq     = wrData[dcr_pkg::CONV_RATE_LSB +: dcr_pkg::CONV_RATE_W];
		gateVal_nxt = gateVal_r;
		if (wrEn) begin
			gateVal_nxt = wrData & WR_MASK;
			if (CLIP_EN) begin
				gateVal_nxt[dcr_pkg::CONV_RATE_LSB +: dcr_pkg::CONV_RATE_W] =
					(rateReq > RATE_MAX) ? RATE_MAX : rateReq;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gateVal_r <= RST_VAL;
		end else begin
			gateVal_r <= gateVal_nxt;
		end
	end

	assign gateVal = gateVal_r;

endmodule

// >>> rtl/dcr_pkg.sv
// constants and carriers shared by the device capability register bank
package dcr_pkg;

	//----------------------------------------------------------------
	// register bus
	//----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
		logic              wrStb;
		logic              rdStb;
	} dcr_bus_s;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_DEEP
	} dcr_mode_e;

	//----------------------------------------------------------------
	// capability register offsets
	//----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_MEMORY_SIZE_CAPABILITY  = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_CORE_DEBUG_CAPABILITY   = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_PERIPHERAL_CAPABILITY   = 12'h014;

	//----------------------------------------------------------------
	// gating register offsets and indices
	//----------------------------------------------------------------
	localparam int GATE_N     = 6;
	localparam int G_RUN0     = 0;
	localparam int G_RUN1     = 1;
	localparam int G_SLEEP0   = 2;
	localparam int G_SLEEP1   = 3;
	localparam int G_DEEP0    = 4;
	localparam int G_DEEP1    = 5;
	localparam logic [ADDR_W-1:0] GATE_OFS [GATE_N] = '{
		12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124
	};
	localparam logic [DATA_W-1:0] GATE_RST = 32'h0000_0000;

	//----------------------------------------------------------------
	// memory size capability fields
	//----------------------------------------------------------------
	localparam int SRAM_SIZE_LSB  = 16;
	localparam int FLASH_SIZE_LSB = 0;
	localparam logic [15:0] SRAM_SIZE_FIELD  = 16'h0007;
	localparam logic [15:0] FLASH_SIZE_FIELD = 16'h0003;

	//----------------------------------------------------------------
	// core and debug capability fields
	//----------------------------------------------------------------
	localparam int MIN_SYS_DIV_LSB  = 12;
	localparam int MEM_PROT_BIT     = 7;
	localparam int PLL_BIT          = 4;
	localparam int WATCHDOG_BIT     = 3;
	localparam int TRACE_OUT_BIT    = 2;
	localparam int SERIAL_DEBUG_BIT = 1;
	localparam int JTAG_BIT         = 0;
	localparam logic [3:0] MINIMUM_SYSTEM_DIVIDER = 4'h9;
	localparam logic       MEMORY_PROTECTION_PRESENT = 1'h0;

	//----------------------------------------------------------------
	// peripheral capability fields
	//----------------------------------------------------------------
	localparam int COMPARATOR_ONE_BIT  = 25;
	localparam int COMPARATOR_ZERO_BIT = 24;
	localparam int TIMER_ONE_BIT       = 17;
	localparam int TIMER_ZERO_BIT      = 16;
	localparam int SYNC_SERIAL_BIT     = 4;
	localparam int FIRST_UART_BIT      = 0;

	//----------------------------------------------------------------
	// fixed register images and write masks
	//----------------------------------------------------------------
	localparam logic [DATA_W-1:0] MEMORY_SIZE_CAPABILITY  = 32'h0007_0003;
	localparam logic [DATA_W-1:0] CORE_DEBUG_CAPABILITY   = 32'h0000_901F;
	localparam logic [DATA_W-1:0] PERIPHERAL_CAPABILITY   = 32'h0303_0011;
	localparam logic [DATA_W-1:0] GROUP0_MASK             = 32'h0000_000F;
	localparam logic [DATA_W-1:0] GROUP1_MASK             = PERIPHERAL_CAPABILITY;
	localparam logic [DATA_W-1:0] RESERVED_CORE_MASK      = 32'hFFFF_0F60;

	//----------------------------------------------------------------
	// converter sample rate field in group 0 gating registers
	//----------------------------------------------------------------
	localparam int         CONV_RATE_LSB = 8;
	localparam int         CONV_RATE_W   = 2;
	localparam logic [1:0] CONV_RATE_MAX = 2'h0;
	localparam logic [DATA_W-1:0] CONV_RATE_FIELD = 32'h0000_0300;

endpackage

// >>> verif/dcr_capability_regs_tb.sv
// self-checking bench for the capability registers and masked gating registers
`timescale 1ns/1ps

`define CMP(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); \
	end \
end

module dcr_capability_regs_tb;

	logic                mclk = 1'b0;
	logic                sys_rst;
	dcr_pkg::dcr_bus_s   busIn;
	dcr_pkg::dcr_mode_e  powerMode;
	logic [31:0]         rdData_r;
	logic [31:0]         gateRun0_r;
	logic [31:0]         gateRun1_r;
	logic [31:0]         gateSleep0_r;
	logic [31:0]         gateSleep1_r;
	logic [31:0]         gateDeep0_r;
	logic [31:0]         gateDeep1_r;
	logic [31:0]         activeGate0_r;
	logic [31:0]         activeGate1_r;
	logic                rdSeen;
	logic [31:0]         expRd;
	logic [31:0]         g [6];
	logic [31:0]         expQ [$];
	int                  bad_count;
	int                  cmp_count;

	dcr_capability_regs u_dcr_capability_regs (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.busIn         (busIn),
		.powerMode     (powerMode),
		.rdData_r      (rdData_r),
		.gateRun0_r    (gateRun0_r),
		.gateRun1_r    (gateRun1_r),
		.gateSleep0_r  (gateSleep0_r),
		.gateSleep1_r  (gateSleep1_r),
		.gateDeep0_r   (gateDeep0_r),
		.gateDeep1_r   (gateDeep1_r),
		.activeGate0_r (activeGate0_r),
		.activeGate1_r (activeGate1_r)
	);

	//----------------------------------------------------------------
	// behavioural model
	//----------------------------------------------------------------
	function automatic logic [31:0] mask_of(input int i, input logic [31:0] d);
		logic [1:0] rate;
		// group 0: watchdog, trace, debug, jtag only; rate clipped to max 0
		rate = (d[9:8] > 2'h0) ? 2'h0 : d[9:8];
		if (i % 2 == 0)
			return (d & 32'h0000_000F) | {22'h0, rate, 8'h00};
		return d & 32'h0303_0011;
	endfunction

	function automatic logic [31:0] exp_read(input logic [11:0] a);
		case (a)
			12'h008: return 32'h0007_0003;
			12'h010: return 32'h0000_901F;
			12'h014: return 32'h0303_0011;
			default: begin
				for (int i = 0; i < 6; i++)
					if (dcr_pkg::GATE_OFS[i] == a)
						return g[i];
				return 32'h0000_0000;
			end
		endcase
	endfunction

	//----------------------------------------------------------------
	// bus driver and checks
	//----------------------------------------------------------------
	task automatic cyc(input logic [11:0] a, input logic [31:0] d, input logic w, input logic r);
		@(posedge mclk);
		busIn <= '{addr: a, wrData: d, wrStb: w, rdStb: r};
		if (r)
			expQ.push_back(exp_read(a));
		if (w)
			for (int i = 0; i < 6; i++)
				if (dcr_pkg::GATE_OFS[i] == a)
					g[i] = mask_of(i, d);
	endtask

	task automatic check_gates();
		logic [31:0] ports [6];
		int          sel;
		@(posedge mclk);
		busIn.wrStb <= 1'b0;
		busIn.rdStb <= 1'b0;
		@(posedge mclk);
		@(negedge mclk);
		ports = '{gateRun0_r, gateRun1_r, gateSleep0_r, gateSleep1_r, gateDeep0_r, gateDeep1_r};
		for (int i = 0; i < 6; i++)
			`CMP(ports[i], g[i])
		sel = (powerMode == dcr_pkg::MODE_SLEEP) ? 2 : (powerMode == dcr_pkg::MODE_DEEP) ? 4 : 0;
		`CMP(activeGate0_r, g[sel])
		`CMP(activeGate1_r, g[sel + 1])
	endtask

	task automatic tally_and_finish();
		$display("errors %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// read answer stands only in the cycle after the strobe
	always @(posedge mclk) begin
		rdSeen <= busIn.rdStb & ~sys_rst;
	end

	always @(negedge mclk) begin
		if (!sys_rst) begin
			expRd = rdSeen ? expQ.pop_front() : 32'h0000_0000;
			`CMP(rdData_r, expRd)
		end
	end

	//----------------------------------------------------------------
	// clock, watchdog, stimulus
	//----------------------------------------------------------------
	always #25 mclk = ~mclk;

	initial begin
		#2_000_000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		logic [11:0] capOfs [7];
		logic [31:0] d;
		sys_rst = 1'b1;
		busIn = '0;
		powerMode = dcr_pkg::MODE_RUN;
		bad_count = 0;
		cmp_count = 0;
		for (int i = 0; i < 6; i++)
			g[i] = 32'h0000_0000;
		capOfs = '{12'h008, 12'h010, 12'h014, 12'h00C, 12'h018, 12'h000, 12'hFFC};
		void'($urandom(98774));
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		check_gates();
		// back-to-back reads of capability and unmapped places
		for (int i = 0; i < 7; i++)
			cyc(capOfs[i], 32'h0000_0000, 1'b0, 1'b1);
		// writes to read-only places, each read straight back
		for (int i = 0; i < 7; i++) begin
			cyc(capOfs[i], $urandom, 1'b1, 1'b0);
			cyc(capOfs[i], 32'h0000_0000, 1'b0, 1'b1);
		end
		check_gates();
		// masked gating writes in every power mode
		for (int n = 0; n < 30; n++) begin
			d = (n < 6) ? 32'hFFFF_FFFF : $urandom;
			@(posedge mclk);
			powerMode <= dcr_pkg::dcr_mode_e'(2'($urandom_range(3)));
			cyc(dcr_pkg::GATE_OFS[n % 6], d, 1'b1, 1'b0);
			cyc(dcr_pkg::GATE_OFS[n % 6], 32'h0000_0000, 1'b0, 1'b1);
			check_gates();
		end
		for (int i = 0; i < 6; i++)
			cyc(dcr_pkg::GATE_OFS[i], 32'h0000_0000, 1'b0, 1'b1);
		check_gates();
		// reset in mid-run clears the gating registers
		@(posedge mclk);
		sys_rst <= 1'b1;
		busIn <= '0;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			g[i] = 32'h0000_0000;
		check_gates();
		for (int i = 0; i < 3; i++)
			cyc(capOfs[i], 32'h0000_0000, 1'b0, 1'b1);
		check_gates();
		tally_and_finish();
	end

endmodule
